// [design/mlsc_map.svh]
// Offsets, field positions, reset values and timing counts of the low-speed control block.
`ifndef MLSC_MAP_SVH
`define MLSC_MAP_SVH

// Clock rate and the least module reset pulse, in its own unit.
`define MLSC_CLK_MHZ 200
`define MLSC_RESET_MIN_NS 1000
`define MLSC_RESET_MIN_CYCLES ((`MLSC_RESET_MIN_NS * `MLSC_CLK_MHZ + 999) / 1000)

// Lane count and the serial device address (the address value is arbitrary).
`define MLSC_LANES 4
`define MLSC_DEV_ADDR 7'h50

// APB register byte addresses.
`define MLSC_APB_CTRL 8'h00
`define MLSC_APB_IRQ_STATUS 8'h04
`define MLSC_APB_IRQ_MASK 8'h08
`define MLSC_APB_LOS_THRESH 8'h0c
`define MLSC_APB_RX_POWER 8'h10
`define MLSC_APB_PIN_STATUS 8'h14

// Interrupt status and mask fields.
`define MLSC_IRQ_RESET_DONE 0
`define MLSC_IRQ_LOS_CHANGE 1
`define MLSC_IRQ_HOST_WRITE 2

// Register reset values.
`define MLSC_LOS_THRESH_RST 8'h10

// Host-side serial byte map.
`define MLSC_HB_STATUS 8'h00
`define MLSC_HB_FLAGS 8'h01
`define MLSC_HB_LOS 8'h02
`define MLSC_HB_TX_CTRL 8'h03
`define MLSC_HB_RXPOW0 8'h04

// Host flag fields, cleared when the flag byte is read.
`define MLSC_HF_RESET_DONE 0
`define MLSC_HF_LOS 1
`define MLSC_HF_FAULT 2

`endif

// [design/mlsc_pkg.sv]
// Types shared by the low-speed control block.
`default_nettype none

package mlsc_pkg;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_DEV,
		I2C_REG,
		I2C_WR,
		I2C_RD
	} mlsc_i2c_state_e;

	typedef logic [7:0] mlsc_byte_t;

endpackage

`default_nettype wire

// [design/mlsc_if.sv]
// Byte access channel between the serial slave and the host byte map.
`timescale 1ns/100ps
`default_nettype none

interface mlsc_if;
	logic [7:0] addr;
	logic wr_en;
	logic [7:0] wr_data;
	logic rd_en;
	logic [7:0] rd_data;

	modport link (output addr, output wr_en, output wr_data, output rd_en, input rd_data);
	modport regs (input addr, input wr_en, input wr_data, input rd_en, output rd_data);
endinterface

`default_nettype wire

// [design/mlsc_i2c_slave.sv]
// Two-wire serial slave that turns host transactions into byte accesses.
`timescale 1ns/100ps
`default_nettype none
`include "mlsc_map.svh"

module mlsc_i2c_slave
	import mlsc_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = `MLSC_DEV_ADDR
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Serial pins and select.
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic enable_in,
	output logic sda_low_out,
	// Byte access channel.
	mlsc_if.link bus
);

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_d_r;
	logic sda_d_r;
	mlsc_i2c_state_e state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	mlsc_byte_t shift_r, shift_nxt;
	mlsc_byte_t ptr_r, ptr_nxt;
	logic ack_r, ack_nxt;
	logic sda_low_r, sda_low_nxt;
	logic wr_en, rd_en;
	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire start_seen;
	wire stop_seen;

	// Two-stage synchronisers on both pins, then one delayed copy for edges.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end

	// Bus conditions seen on the synchronised pins.
	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// Transaction sequencer: bits are taken on clock rise, driven on clock fall.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		ack_nxt = ack_r;
		sda_low_nxt = sda_low_r;
		wr_en = 1'b0;
		rd_en = 1'b0;
		if (!enable_in || stop_seen) begin
			state_nxt = I2C_IDLE;
			cnt_nxt = 4'h0;
			ack_nxt = 1'b0;
			sda_low_nxt = 1'b0;
		end else if (start_seen) begin
			state_nxt = I2C_DEV;
			cnt_nxt = 4'h0;
			ack_nxt = 1'b0;
			sda_low_nxt = 1'b0;
		end else if (scl_rise && !ack_r && state_r != I2C_IDLE) begin
			if (state_r == I2C_RD) begin
				if (cnt_r == 4'h8) begin
					cnt_nxt = 4'h0;
					if (sda_s) begin
						state_nxt = I2C_IDLE;
					end
				end else begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end else begin
				shift_nxt = {shift_r[6:0], sda_s};
				cnt_nxt = cnt_r + 4'h1;
			end
		end else if (scl_fall && state_r != I2C_IDLE) begin
			if (ack_r || (state_r == I2C_RD && cnt_r == 4'h0)) begin
				ack_nxt = 1'b0;
				sda_low_nxt = 1'b0;
				if (state_r == I2C_RD) begin
					rd_en = 1'b1;
					shift_nxt = bus.rd_data;
					sda_low_nxt = ~bus.rd_data[7];
					ptr_nxt = ptr_r + 8'h01;
				end
			end else if (state_r == I2C_RD) begin
				if (cnt_r < 4'h8) begin
					sda_low_nxt = ~shift_r[6];
					shift_nxt = {shift_r[6:0], 1'b0};
				end else begin
					sda_low_nxt = 1'b0;
				end
			end else if (cnt_r == 4'h8) begin
				cnt_nxt = 4'h0;
				if (state_r == I2C_DEV) begin
					if (shift_r[7:1] == DEVICE_ADDR) begin
						ack_nxt = 1'b1;
						sda_low_nxt = 1'b1;
						state_nxt = shift_r[0] ? I2C_RD : I2C_REG;
					end else begin
						state_nxt = I2C_IDLE;
					end
				end else if (state_r == I2C_REG) begin
					ptr_nxt = shift_r;
					ack_nxt = 1'b1;
					sda_low_nxt = 1'b1;
					state_nxt = I2C_WR;
				end else begin
					wr_en = 1'b1;
					ptr_nxt = ptr_r + 8'h01;
					ack_nxt = 1'b1;
					sda_low_nxt = 1'b1;
				end
			end
		end
	end

	// Sequencer state.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= I2C_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			ack_r <= 1'b0;
			sda_low_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			ack_r <= ack_nxt;
			sda_low_r <= sda_low_nxt;
		end
	end

	// Byte channel toward the host byte map.
	assign bus.addr = ptr_r;
	assign bus.wr_data = shift_r;
	assign bus.wr_en = wr_en;
	assign bus.rd_en = rd_en;
	assign sda_low_out = sda_low_r;

	// A deselected module leaves the bus alone.
	a_deselect_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!enable_in |=> state_r == I2C_IDLE && !sda_low_out ##1 !sda_low_out)
		else $error("serial slave active while deselected");
	a_foreign_nack: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(enable_in && scl_fall && state_r == I2C_DEV && cnt_r == 4'h8 && !ack_r &&
		shift_r[7:1] != DEVICE_ADDR && !start_seen) |=> !sda_low_out && state_r == I2C_IDLE)
		else $error("slave answered a foreign address");
	c_host_write: cover property (@(posedge clk_in) disable iff (!reset_n_in) wr_en);
	c_host_read: cover property (@(posedge clk_in) disable iff (!reset_n_in) rd_en);

endmodule

`default_nettype wire

// [design/mlsc_top.sv]
// Low-speed management and control logic of a pluggable four-lane optical module.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "mlsc_map.svh"

module mlsc_top
	import mlsc_pkg::*;
#(
	parameter int unsigned RESET_MIN_CYCLES = `MLSC_RESET_MIN_CYCLES,
	parameter logic [6:0] DEVICE_ADDR = `MLSC_DEV_ADDR
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// APB register port.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	// Host-facing low-speed pins.
	input wire logic module_select_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic module_reset_n_in,
	input wire logic low_power_request_in,
	output logic module_present_n_out,
	output logic module_present_n_oe_out,
	output logic interrupt_n_out,
	output logic interrupt_n_oe_out,
	input wire logic tx_disable_in,
	// Optical front end.
	input wire logic [`MLSC_LANES*8-1:0] rx_power_in,
	output logic [`MLSC_LANES-1:0] tx_off_out,
	output logic [`MLSC_LANES-1:0] rx_loss_of_signal_out,
	output logic low_power_out
);

	localparam int LANES = `MLSC_LANES;
	localparam logic [15:0] RST_MIN = 16'(RESET_MIN_CYCLES);

	mlsc_if bus ();
	logic [3:0] pin_sync1_r;
	logic [3:0] pin_sync2_r;
	logic [15:0] rst_cnt_r, rst_cnt_nxt;
	logic init_pending_r;
	logic [2:0] host_flags_r, host_flags_nxt;
	logic int_oe_r;
	logic [LANES-1:0] serial_txdis_r;
	logic [LANES-1:0] tx_off_r;
	logic [LANES-1:0] rx_loss_of_signal_r;
	logic [LANES-1:0] los_now;
	logic low_power_r;
	logic fault_req_r;
	logic [2:0] irq_status_r, irq_status_nxt;
	logic [2:0] irq_mask_r;
	logic irq_r;
	logic [7:0] los_thresh_r;
	logic [31:0] prdata_r;
	logic [1:0] up_cnt_r;
	logic sda_low;
	wire pin_txdis;
	wire pin_lowpow;
	wire pin_reset_low;
	wire pin_selected;
	wire mod_reset_active;
	wire reset_done_pulse;
	wire los_change;
	wire [2:0] host_flag_set;
	wire [2:0] host_flag_clr;
	wire [7:0] host_rd_byte;
	wire apb_setup;
	wire apb_access;
	wire apb_wr;
	wire hit_ctrl, hit_stat, hit_mask, hit_thr, hit_pow, hit_pins;
	wire apb_mapped;
	wire [31:0] apb_rd_word;
	wire [2:0] irq_event;
	wire [2:0] irq_w1c;

	// Pin inputs pass two flip-flops: tx disable, low power, reset, select.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_sync1_r <= 4'hc;
			pin_sync2_r <= 4'hc;
		end else begin
			pin_sync1_r <= {module_select_n_in, module_reset_n_in, low_power_request_in, tx_disable_in};
			pin_sync2_r <= pin_sync1_r;
		end
	end

	// Synchronised pin levels.
	assign pin_txdis = pin_sync2_r[0];
	assign pin_lowpow = pin_sync2_r[1];
	assign pin_reset_low = ~pin_sync2_r[2];
	assign pin_selected = ~pin_sync2_r[3];

	// Reset pulse qualifier: the reset takes hold only after the minimum low time.
	assign rst_cnt_nxt = !pin_reset_low ? 16'h0000 :
		(rst_cnt_r == RST_MIN) ? rst_cnt_r : rst_cnt_r + 16'h0001;
	assign mod_reset_active = (rst_cnt_r == RST_MIN);
	assign reset_done_pulse = init_pending_r & ~mod_reset_active;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_cnt_r <= 16'h0000;
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
		end
	end

	// Init pending is set by power-up and by a module reset, cleared when it ends.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			init_pending_r <= 1'b1;
		end else begin
			init_pending_r <= mod_reset_active;
		end
	end

	// Per-lane loss-of-signal compare against the software threshold.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign los_now[g] = rx_power_in[g*8 +: 8] < los_thresh_r;
		end
	endgenerate
	assign los_change = |(los_now & ~rx_loss_of_signal_r);

	// Transmitter, alarm and low-power outputs, registered.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_off_r <= '0;
			rx_loss_of_signal_r <= '0;
			low_power_r <= 1'b0;
		end else begin
			tx_off_r <= {LANES{pin_txdis}} | serial_txdis_r;
			rx_loss_of_signal_r <= los_now;
			low_power_r <= pin_lowpow;
		end
	end

	// Host flags: set wins over the clear made by reading the flag byte.
	assign host_flag_set = {fault_req_r, los_change, reset_done_pulse};
	assign host_flag_clr = (bus.rd_en && bus.addr == `MLSC_HB_FLAGS) ? 3'h7 :
		(mod_reset_active ? 3'h7 : 3'h0);
	assign host_flags_nxt = (host_flags_r & ~host_flag_clr) | host_flag_set;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			host_flags_r <= 3'h0;
			int_oe_r <= 1'b0;
		end else begin
			host_flags_r <= host_flags_nxt;
			int_oe_r <= |host_flags_nxt;
		end
	end

	// Serial transmit-disable setting, returned to default by a module reset.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			serial_txdis_r <= '0;
		end else if (mod_reset_active) begin
			serial_txdis_r <= '0;
		end else if (bus.wr_en && bus.addr == `MLSC_HB_TX_CTRL) begin
			serial_txdis_r <= bus.wr_data[LANES-1:0];
		end
	end

	// Host byte map read selection.
	assign host_rd_byte = (bus.addr == `MLSC_HB_STATUS) ? {7'h00, init_pending_r} :
		(bus.addr == `MLSC_HB_FLAGS) ? {5'h00, host_flags_r} :
		(bus.addr == `MLSC_HB_LOS) ? {4'h0, rx_loss_of_signal_r} :
		(bus.addr == `MLSC_HB_TX_CTRL) ? {4'h0, serial_txdis_r} :
		(bus.addr[7:2] == 6'(`MLSC_HB_RXPOW0 >> 2)) ? rx_power_in[{bus.addr[1:0], 3'b000} +: 8] :
		8'h00;
	assign bus.rd_data = host_rd_byte;

	// Serial slave, enabled only while selected and out of reset.
	mlsc_i2c_slave #(
		.DEVICE_ADDR(DEVICE_ADDR)
	) u_slave (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.enable_in(pin_selected & ~mod_reset_active),
		.sda_low_out(sda_low),
		.bus(bus)
	);

	// APB decode: zero-wait access phase, error on unmapped addresses.
	assign apb_setup = psel_in & ~penable_in;
	assign apb_access = psel_in & penable_in;
	assign apb_wr = apb_access & pwrite_in;
	assign hit_ctrl = (paddr_in == `MLSC_APB_CTRL);
	assign hit_stat = (paddr_in == `MLSC_APB_IRQ_STATUS);
	assign hit_mask = (paddr_in == `MLSC_APB_IRQ_MASK);
	assign hit_thr = (paddr_in == `MLSC_APB_LOS_THRESH);
	assign hit_pow = (paddr_in == `MLSC_APB_RX_POWER);
	assign hit_pins = (paddr_in == `MLSC_APB_PIN_STATUS);
	assign apb_mapped = hit_ctrl | hit_stat | hit_mask | hit_thr | hit_pow | hit_pins;
	assign apb_rd_word = hit_ctrl ? {31'h0, fault_req_r} :
		hit_stat ? {29'h0, irq_status_r} :
		hit_mask ? {29'h0, irq_mask_r} :
		hit_thr ? {24'h000000, los_thresh_r} :
		hit_pow ? rx_power_in :
		hit_pins ? {22'h0, serial_txdis_r, init_pending_r, mod_reset_active, pin_sync2_r} :
		32'h00000000;

	// Read data is captured in the setup cycle and held through the access.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_r <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_r <= apb_rd_word;
		end
	end

	// Writable APB registers.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fault_req_r <= 1'b0;
			irq_mask_r <= 3'h0;
			los_thresh_r <= `MLSC_LOS_THRESH_RST;
		end else if (apb_wr) begin
			fault_req_r <= hit_ctrl ? pwdata_in[0] : fault_req_r;
			irq_mask_r <= hit_mask ? pwdata_in[2:0] : irq_mask_r;
			los_thresh_r <= hit_thr ? pwdata_in[7:0] : los_thresh_r;
		end
	end

	// Sticky interrupt status, write one to clear, set wins over clear.
	assign irq_event[`MLSC_IRQ_RESET_DONE] = reset_done_pulse;
	assign irq_event[`MLSC_IRQ_LOS_CHANGE] = los_change;
	assign irq_event[`MLSC_IRQ_HOST_WRITE] = bus.wr_en;
	assign irq_w1c = (apb_wr && hit_stat) ? pwdata_in[2:0] : 3'h0;
	assign irq_status_nxt = (irq_status_r & ~irq_w1c) | irq_event;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_status_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// Cycles since reset release, saturating, for the power-up check.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			up_cnt_r <= 2'h0;
		end else if (up_cnt_r != 2'h3) begin
			up_cnt_r <= up_cnt_r + 2'h1;
		end
	end

	// Output pins: open-drain lines only ever pull low.
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_low;
	assign interrupt_n_out = 1'b0;
	assign interrupt_n_oe_out = int_oe_r;
	assign module_present_n_out = 1'b0;
	assign module_present_n_oe_out = 1'b1;
	assign tx_off_out = tx_off_r;
	assign rx_loss_of_signal_out = rx_loss_of_signal_r;
	assign low_power_out = low_power_r;
	assign prdata_out = prdata_r;
	assign pready_out = apb_access;
	assign pslverr_out = apb_access & ~apb_mapped;
	assign irq_out = irq_r;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_tx_pin_off: assert property (pin_txdis |=> &tx_off_out)
		else $error("transmitter on while disable pin high");
	a_tx_serial_off: assert property (serial_txdis_r[0] && !mod_reset_active |=> tx_off_out[0])
		else $error("lane 0 on while serial disable set");
	a_los_raise: assert property (los_now[2] |=> rx_loss_of_signal_out[2] && host_flags_r[1] ||
		$past(rx_loss_of_signal_r[2]))
		else $error("weak lane raised no alarm");
	a_power_read: assert property (bus.rd_en && bus.addr == `MLSC_HB_RXPOW0 + 8'h02 |->
		bus.rd_data == rx_power_in[23:16])
		else $error("lane power read back wrong");
	a_short_reset: assert property (pin_reset_low && rst_cnt_r < RST_MIN - 16'h0001 |=>
		!mod_reset_active)
		else $error("short reset pulse took effect");
	a_reset_clears: assert property (mod_reset_active |=> serial_txdis_r == '0 &&
		init_pending_r && host_flags_r[0] == 1'b0)
		else $error("module reset left settings in place");
	a_reset_done_int: assert property ($fell(init_pending_r) |-> interrupt_n_oe_out &&
		host_flags_r[0] ##1 host_flags_r[0] || $past(bus.rd_en))
		else $error("reset completion not posted");
	a_power_up_int: assert property (up_cnt_r == 2'h1 |-> host_flags_r[0] && interrupt_n_oe_out)
		else $error("power-up completion not posted");
	a_fault_int: assert property (fault_req_r [*2] |-> interrupt_n_oe_out && !interrupt_n_out)
		else $error("fault did not pull interrupt low");
	a_low_power: assert property ($rose(pin_lowpow) |=> low_power_out)
		else $error("low power request not applied");
	a_present_low: assert property (module_present_n_oe_out && !module_present_n_out)
		else $error("presence line released");

	c_module_reset: cover property ($rose(mod_reset_active) ##[1:400] reset_done_pulse);
	c_los_irq: cover property (los_change ##1 irq_status_r[`MLSC_IRQ_LOS_CHANGE]);
	c_fault_int: cover property (fault_req_r ##1 interrupt_n_oe_out);

endmodule

`default_nettype wire

// [bench/mlsc_host_model.sv]
// Host board model: a two-wire bus master that parks its clock high between frames.
`timescale 1ns/100ps
`default_nettype none

module mlsc_host_model (
	// Clock and bus lines.
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	// Both lines start released, so the pull-up holds them high.
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// A quarter of the 80 ns bit time.
	task automatic q();
		repeat (4) @(posedge clk_in);
	endtask

	// Start or repeated start, entered with the clock high or low.
	task automatic start();
		sda_low_out <= 1'b0;
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b0;
		q();
	endtask

	// Stop, after which both lines stay released.
	task automatic stop();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b0;
		q();
	endtask

	// One bit: data changes only while the clock is low, read at the middle of high.
	task automatic bit_io(input logic b, output logic r);
		sda_low_out <= ~b;
		q();
		scl_out <= 1'b1;
		q();
		r = sda_in;
		q();
		scl_out <= 1'b0;
		q();
	endtask

	// One byte, most significant bit first, then the acknowledge bit.
	task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
		output logic ack_rx);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_tx, ack_rx);
	endtask
endmodule

`default_nettype wire

// [bench/module_low_speed_control_tb.sv]
// Self-checking bench of the low-speed control block.
`timescale 1ns/100ps
`default_nettype none
`include "mlsc_map.svh"

module module_low_speed_control_tb;
	logic clk_in, reset_n_in, psel_in, penable_in, pwrite_in, module_select_n_in;
	logic module_reset_n_in, low_power_request_in, tx_disable_in, scl_in, host_sda_low;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rx_power_in;
	logic pready_out, pslverr_out, irq_out, sda_out, sda_oe_out, module_present_n_out;
	logic module_present_n_oe_out, interrupt_n_out, interrupt_n_oe_out, low_power_out;
	logic [3:0] tx_off_out, rx_loss_of_signal_out;
	wire logic sda_in;
	int error_cnt, comparisons;

	// The data line is pulled up and low while either party pulls it.
	assign sda_in = ~(host_sda_low | (sda_oe_out & ~sda_out));

	always #2.5 clk_in = ~clk_in;

	mlsc_top #(.RESET_MIN_CYCLES(4)) dut (.clk_in, .reset_n_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out,
		.module_select_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .module_reset_n_in,
		.low_power_request_in, .module_present_n_out, .module_present_n_oe_out,
		.interrupt_n_out, .interrupt_n_oe_out, .tx_disable_in, .rx_power_in, .tx_off_out,
		.rx_loss_of_signal_out, .low_power_out);

	mlsc_host_model host (.clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(host_sda_low));

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer: setup, then access until ready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_in);
			if (pready_out === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			summarize();
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(w, r & m, exp);
	endtask

	// Serial write of one byte at a pointer; nak is high if any byte went unanswered.
	task automatic swr(input logic [7:0] p, input logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic a0, a1, a2;
		host.start();
		host.byte_io({`MLSC_DEV_ADDR, 1'b0}, 1'b1, r, a0);
		host.byte_io(p, 1'b1, r, a1);
		host.byte_io(d, 1'b1, r, a2);
		host.stop();
		nak = a0 | a1 | a2;
	endtask

	// Serial read of one byte: pointer write, repeated start, read ended by a refusal.
	task automatic srd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] r;
		logic a;
		host.start();
		host.byte_io({`MLSC_DEV_ADDR, 1'b0}, 1'b1, r, a);
		host.byte_io(p, 1'b1, r, a);
		host.start();
		host.byte_io({`MLSC_DEV_ADDR, 1'b1}, 1'b1, r, a);
		host.byte_io(8'hff, 1'b1, d, a);
		host.stop();
	endtask

	task automatic t_power_up();
		logic [31:0] r;
		logic e;
		repeat (4) @(posedge clk_in);
		check("int_oe", {31'h0, interrupt_n_oe_out}, 32'h1);
		check("present", {30'h0, module_present_n_oe_out, module_present_n_out}, 32'h2);
		rchk("irq_status", `MLSC_APB_IRQ_STATUS, 32'h1, 32'h1);
		rchk("pin_status", `MLSC_APB_PIN_STATUS, 32'h3f, 32'h0c);
		rchk("los_thresh", `MLSC_APB_LOS_THRESH, 32'hff, 32'h10);
		apb(1'b0, 8'h18, 32'h0, r, e);
		check("slverr", {31'h0, e}, 32'h1);
		check("unmapped", r, 32'h0);
	endtask

	task automatic t_los();
		rx_power_in[23:16] <= 8'h05;
		repeat (6) @(posedge clk_in);
		check("los", {28'h0, rx_loss_of_signal_out}, 32'h4);
		rchk("rx_power", `MLSC_APB_RX_POWER, 32'hffffffff, 32'h80058080);
		wr(`MLSC_APB_IRQ_MASK, 32'h2);
		repeat (3) @(posedge clk_in);
		check("irq", {31'h0, irq_out}, 32'h1);
		wr(`MLSC_APB_IRQ_STATUS, 32'h3);
		repeat (3) @(posedge clk_in);
		check("irq_clr", {31'h0, irq_out}, 32'h0);
		rx_power_in[23:16] <= 8'h10;
		repeat (6) @(posedge clk_in);
		check("los_edge", {28'h0, rx_loss_of_signal_out}, 32'h0);
	endtask

	task automatic t_serial();
		logic [7:0] d;
		logic nak;
		module_select_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		srd(`MLSC_HB_FLAGS, d);
		check("flags", {24'h0, d}, 32'h3);
		repeat (4) @(posedge clk_in);
		check("int_free", {31'h0, interrupt_n_oe_out}, 32'h0);
		srd(`MLSC_HB_RXPOW0 + 8'h2, d);
		check("ser_power", {24'h0, d}, 32'h10);
		wr(`MLSC_APB_CTRL, 32'h1);
		repeat (4) @(posedge clk_in);
		check("int_fault", {31'h0, interrupt_n_oe_out}, 32'h1);
		wr(`MLSC_APB_CTRL, 32'h0);
		// A frame for another address must go unanswered.
		host.start();
		host.byte_io(8'h22, 1'b1, d, nak);
		host.stop();
		check("foreign", {31'h0, nak}, 32'h1);
		swr(`MLSC_HB_TX_CTRL, 8'h05, nak);
		repeat (4) @(posedge clk_in);
		check("tx_ser", {27'h0, nak, tx_off_out}, 32'h5);
		tx_disable_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		check("tx_pin", {28'h0, tx_off_out}, 32'hf);
		tx_disable_in <= 1'b0;
		module_select_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		swr(`MLSC_HB_TX_CTRL, 8'h00, nak);
		check("deselect", {27'h0, nak, tx_off_out}, 32'h15);
	endtask

	task automatic t_power_mode();
		low_power_request_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		check("low_power", {31'h0, low_power_out}, 32'h1);
		low_power_request_in <= 1'b0;
	endtask

	task automatic t_module_reset();
		logic [7:0] d;
		module_reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		module_reset_n_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		check("short_rst", {28'h0, tx_off_out}, 32'h5);
		module_reset_n_in <= 1'b0;
		repeat (12) @(posedge clk_in);
		module_reset_n_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		check("long_rst", {28'h0, tx_off_out}, 32'h0);
		check("rst_int", {31'h0, interrupt_n_oe_out}, 32'h1);
		module_select_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		srd(`MLSC_HB_STATUS, d);
		check("init_pend", {24'h0, d}, 32'h0);
	endtask

	// Main sequence: every input set at time zero, reset held for 20 cycles.
	initial begin
		clk_in = 1'b0;
		reset_n_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		module_select_n_in = 1'b1;
		module_reset_n_in = 1'b1;
		low_power_request_in = 1'b0;
		tx_disable_in = 1'b0;
		rx_power_in = {4{8'h80}};
		error_cnt = 0;
		comparisons = 0;
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_power_up();
		t_los();
		t_serial();
		t_power_mode();
		t_module_reset();
		summarize();
	end

	// Cuts a hung run short.
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
endmodule

`default_nettype wire
